// File: src/gauge_i2c_slave.sv
`timescale 1ns/1ps
// Summary of operation
// - high threshold resets to FFFFh, low threshold to 0000h.
// - host may write both thresholds over the serial bus.
// - threshold crossing sets status flag and, in alert mode, pulls alert low.
// - SDA, SCL and alert are only pulled low, never driven high.
// - works at 100 and 400 kbit/s bus rates.
// - slave only; never drives SCL nor starts transfers.
// - detect START and STOP on SDA edges while SCL high.
// - repeated START handled exactly as START.
// - eight data bits plus acknowledge bit per nine SCL cycles.
// - SDA changes only while SCL low, except START and STOP.
// - write: address, command byte to pointer, data to register.
// - further write bytes acknowledged, pointer advanced, next register stored.
// - read after repeated START returns addressed register contents.
// - master ACK advances pointer and sends next register; NAK ends.
// - alert response address acknowledged while alerting; return own address followed by a one bit.
// - lose arbitration on sent one but seen zero; retry next time.
// - after full address sent, release alert until new alert event.
// - alert mode selected when pin configuration field equals 10b.
// - charge overflow or underflow also pulls alert low.
module gauge_i2c_slave
    import gauge_pkg::*;
(
    input wire logic MCLK_I,
    input wire logic SYS_RST_I,
    input wire logic SCL_I,
    input wire logic SDA_I,
    input wire logic CHARGE_UP_I,
    input wire logic CHARGE_DOWN_I,
    output logic SDA_O,
    output logic SDA_OE_N_O,
    output logic SCL_O,
    output logic SCL_OE_N_O,
    output logic ALERT_O,
    output logic ALERT_OE_N_O
);
    import gauge_pkg::*;

    typedef enum {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK, ST_WDATA, ST_WDATA_ACK,
        ST_RDATA, ST_RDATA_ACK, ST_ARA, ST_ARA_ACK
    } state_t;

    state_t state;
    logic scl;
    logic sda;
    logic scl_d;
    logic sda_d;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [3:0] pointer;
    logic pull_sda;
    logic wr_strobe;
    logic [7:0] rdata;
    logic [7:0] control;
    logic [15:0] charge;
    logic [15:0] high_thr;
    logic [15:0] low_thr;
    logic [7:0] status;
    logic flag_high;
    logic flag_low;
    logic flag_ovf;
    logic alert_pending;
    logic alert_mode;
    logic alert_event;
    logic [7:0] ara_byte;
    logic ara_done;

    pin_sync u_scl_sync (
        .clk_i(MCLK_I),
        .rst_i(SYS_RST_I),
        .async_i(SCL_I),
        .sync_o(scl)
    );
    pin_sync u_sda_sync (
        .clk_i(MCLK_I),
        .rst_i(SYS_RST_I),
        .async_i(SDA_I),
        .sync_o(sda)
    );

    assign status = STATUS_FIXED | ({7'h00, flag_ovf} << FLAG_OVERFLOW)
        | ({7'h00, flag_high} << FLAG_HIGH) | ({7'h00, flag_low} << FLAG_LOW);

    reg_bank u_regs (
        .clk_i(MCLK_I),
        .rst_i(SYS_RST_I),
        .wr_i(wr_strobe),
        .waddr_i(pointer),
        .wdata_i(shreg),
        .raddr_i(pointer),
        .status_i(status),
        .rdata_o(rdata),
        .control_o(control),
        .charge_o(charge),
        .high_o(high_thr),
        .low_o(low_thr)
    );

    always_ff @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl;
            sda_d <= sda;
        end
    end

    assign scl_rise = scl && !scl_d;
    assign scl_fall = !scl && scl_d;
    assign start_det = scl && scl_d && sda_d && !sda;
    assign stop_det = scl && scl_d && !sda_d && sda;
    assign alert_mode = control[PIN_MODE_LSB +: 2] == PIN_MODE_ALERT;
    // bit sequencing runs on sampled edges, so 400 kbit/s has ample margin at 200 MHz
    assign wr_strobe = scl_fall && state == ST_WDATA_ACK;

    always_ff @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            pointer <= 4'h0;
            pull_sda <= 1'b0;
            ara_done <= 1'b0;
        end else begin
            ara_done <= 1'b0;
            if (start_det) begin
                state <= ST_ADDR;
                bit_cnt <= 4'h0;
                pull_sda <= 1'b0;
            end else if (stop_det) begin
                state <= ST_IDLE;
                pull_sda <= 1'b0;
            end else if (scl_rise) begin
                case (state)
                    ST_ADDR, ST_CMD, ST_WDATA: begin
                        shreg <= {shreg[6:0], sda};
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    ST_RDATA: begin
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    ST_ARA: begin
                        if (!pull_sda && !sda) begin
                            state <= ST_IDLE;
                            pull_sda <= 1'b0;
                        end
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    ST_RDATA_ACK: begin
                        if (sda) begin
                            state <= ST_IDLE;
                        end else begin
                            pointer <= pointer + 4'h1;
                        end
                    end
                    default: begin
                    end
                endcase
            end else if (scl_fall) begin
                // SDA only moves on the falling SCL edge
                case (state)
                    ST_ADDR: begin
                        if (bit_cnt == 4'h8) begin
                            if (shreg[7:1] == OWN_ADDR) begin
                                state <= ST_ADDR_ACK;
                                pull_sda <= 1'b1;
                            end else if (shreg[7:1] == ALERT_RESP_ADDR && shreg[0]
                                && alert_pending && alert_mode) begin
                                state <= ST_ARA_ACK;
                                pull_sda <= 1'b1;
                            end else begin
                                state <= ST_IDLE;
                            end
                        end
                    end
                    ST_ADDR_ACK: begin
                        bit_cnt <= 4'h0;
                        if (shreg[0]) begin
                            state <= ST_RDATA;
                            pull_sda <= !rdata[7];
                            shreg <= {rdata[6:0], 1'b1};
                        end else begin
                            state <= ST_CMD;
                            pull_sda <= 1'b0;
                        end
                    end
                    ST_CMD, ST_WDATA: begin
                        if (bit_cnt == 4'h8) begin
                            state <= state == ST_CMD ? ST_CMD_ACK : ST_WDATA_ACK;
                            pull_sda <= 1'b1;
                        end
                    end
                    ST_CMD_ACK: begin
                        pointer <= shreg[3:0];
                        state <= ST_WDATA;
                        bit_cnt <= 4'h0;
                        pull_sda <= 1'b0;
                    end
                    ST_WDATA_ACK: begin
                        pointer <= pointer + 4'h1;
                        state <= ST_WDATA;
                        bit_cnt <= 4'h0;
                        pull_sda <= 1'b0;
                    end
                    ST_RDATA: begin
                        if (bit_cnt == 4'h8) begin
                            state <= ST_RDATA_ACK;
                            pull_sda <= 1'b0;
                        end else begin
                            pull_sda <= !shreg[7];
                            shreg <= {shreg[6:0], 1'b1};
                        end
                    end
                    ST_RDATA_ACK: begin
                        // pointer already advanced, so this byte is the next register
                        state <= ST_RDATA;
                        bit_cnt <= 4'h0;
                        pull_sda <= !rdata[7];
                        shreg <= {rdata[6:0], 1'b1};
                    end
                    ST_ARA_ACK: begin
                        state <= ST_ARA;
                        bit_cnt <= 4'h0;
                        pull_sda <= !ara_byte[7];
                        shreg <= {ara_byte[6:0], 1'b1};
                    end
                    ST_ARA: begin
                        if (bit_cnt == 4'h8) begin
                            state <= ST_RDATA_ACK;
                            pull_sda <= 1'b0;
                            ara_done <= 1'b1;
                        end else begin
                            pull_sda <= !shreg[7];
                            shreg <= {shreg[6:0], 1'b1};
                        end
                    end
                    default: begin
                        pull_sda <= 1'b0;
                    end
                endcase
            end
        end
    end

    assign ara_byte = {OWN_ADDR, 1'b1};
    // a flag already set raises no new event, so a released alert stays released
    assign alert_event = (charge > high_thr && !flag_high) || (charge < low_thr && !flag_low)
        || ((CHARGE_UP_I || CHARGE_DOWN_I) && !flag_ovf);

    // flags are sticky; a new event wins over the release done by an alert response
    always_ff @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            flag_high <= 1'b0;
            flag_low <= 1'b0;
            flag_ovf <= 1'b0;
            alert_pending <= 1'b0;
        end else begin
            if (charge > high_thr) begin
                flag_high <= 1'b1;
            end
            if (charge < low_thr) begin
                flag_low <= 1'b1;
            end
            if (CHARGE_UP_I || CHARGE_DOWN_I) begin
                flag_ovf <= 1'b1;
            end
            if (alert_event) begin
                alert_pending <= 1'b1;
            end else if (ara_done) begin
                alert_pending <= 1'b0;
            end
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            SDA_O <= 1'b0;
            SDA_OE_N_O <= 1'b1;
            SCL_O <= 1'b0;
            SCL_OE_N_O <= 1'b1;
            ALERT_O <= 1'b0;
            ALERT_OE_N_O <= 1'b1;
        end else begin
            SDA_O <= 1'b0;
            SDA_OE_N_O <= !pull_sda;
            SCL_O <= 1'b0;
            SCL_OE_N_O <= 1'b1;
            ALERT_O <= 1'b0;
            ALERT_OE_N_O <= !(alert_pending && alert_mode);
        end
    end

    a_sda_low_only: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        SDA_O == 1'b0) else $error("sda driven high");
    a_scl_released: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        SCL_OE_N_O) else $error("scl driven");
    a_start_restarts: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        start_det |=> state == ST_ADDR && bit_cnt == 4'h0) else $error("start missed");
    a_stop_idles: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        stop_det && !start_det |=> state == ST_IDLE) else $error("stop missed");
    a_sda_moves_scl_low: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        $changed(pull_sda) && !$past(start_det) && !$past(stop_det) |-> !scl_d)
        else $error("sda moved with scl high");
    a_high_flag_sets: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        charge > high_thr |=> flag_high) else $error("high flag not set");
    a_low_flag_sets: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        charge < low_thr |=> flag_low) else $error("low flag not set");
    a_alert_pin: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        alert_pending && alert_mode |=> !ALERT_OE_N_O) else $error("alert not pulled");
    a_ara_release: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        ara_done && !alert_event |=> !alert_pending) else $error("alert kept");
    a_foreign_ignored: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        scl_fall && state == ST_ADDR && bit_cnt == 4'h8 && shreg[7:1] != OWN_ADDR
        && shreg[7:1] != ALERT_RESP_ADDR |=> state == ST_IDLE && !pull_sda)
        else $error("foreign address answered");
    a_write_pointer: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        wr_strobe |=> pointer == $past(pointer) + 4'h1) else $error("pointer stuck");
    a_ara_refused: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        scl_fall && state == ST_ADDR && bit_cnt == 4'h8 && shreg[7:1] == ALERT_RESP_ADDR
        && !(alert_pending && alert_mode) |=> state == ST_IDLE && !pull_sda)
        else $error("alert response answered while quiet");
    a_lost_drops: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        state == ST_ARA && scl_rise && !pull_sda && !sda
        |=> state == ST_IDLE && alert_pending)
        else $error("arbitration loss ignored");
    a_mode_gate: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        !alert_mode |=> ALERT_OE_N_O) else $error("alert pulled outside alert mode");
    a_ovf_flag: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        CHARGE_UP_I || CHARGE_DOWN_I |=> flag_ovf) else $error("overflow flag not set");
    a_read_nak: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        state == ST_RDATA_ACK && scl_rise && sda |=> state == ST_IDLE) else $error("nak ignored");

    c_write: cover property (@(posedge MCLK_I) wr_strobe);
    c_mode_off: cover property (@(posedge MCLK_I) !alert_mode && alert_pending);
    c_read_ack: cover property (@(posedge MCLK_I) state == ST_RDATA_ACK && scl_rise && !sda);
    c_ara_done: cover property (@(posedge MCLK_I) ara_done);
    c_ara_lost: cover property (@(posedge MCLK_I) state == ST_ARA && scl_rise && !pull_sda && !sda);
endmodule // gauge_i2c_slave

// File: src/gauge_pkg.sv
package gauge_pkg;
    localparam logic [6:0] OWN_ADDR = 7'h64;
    localparam logic [6:0] ALERT_RESP_ADDR = 7'h0C;
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_CONTROL = 4'h1;
    localparam logic [3:0] REG_CHARGE_MSB = 4'h2;
    localparam logic [3:0] REG_CHARGE_LSB = 4'h3;
    localparam logic [3:0] REG_HIGH_MSB = 4'h4;
    localparam logic [3:0] REG_HIGH_LSB = 4'h5;
    localparam logic [3:0] REG_LOW_MSB = 4'h6;
    localparam logic [3:0] REG_LOW_LSB = 4'h7;
    localparam int REG_COUNT = 8;
    localparam logic [7:0] CONTROL_RESET = 8'h3C;
    localparam logic [15:0] CHARGE_RESET = 16'h7FFF;
    localparam logic [15:0] HIGH_RESET = 16'hFFFF;
    localparam logic [15:0] LOW_RESET = 16'h0000;
    localparam logic [1:0] PIN_MODE_ALERT = 2'h2;
    localparam int PIN_MODE_LSB = 1;
    localparam int FLAG_CHIP_ID = 7;
    localparam int FLAG_OVERFLOW = 5;
    localparam int FLAG_HIGH = 3;
    localparam int FLAG_LOW = 2;
    localparam logic [7:0] STATUS_FIXED = 8'h80;
endpackage : gauge_pkg

// File: src/pin_sync.sv
`timescale 1ns/1ps
module pin_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic async_i,
    output logic sync_o
);
    logic stage;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stage <= 1'b1;
            sync_o <= 1'b1;
        end else begin
            stage <= async_i;
            sync_o <= stage;
        end
    end
endmodule // pin_sync

// File: src/reg_bank.sv
`timescale 1ns/1ps
module reg_bank
    import gauge_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wr_i,
    input wire logic [3:0] waddr_i,
    input wire logic [7:0] wdata_i,
    input wire logic [3:0] raddr_i,
    input wire logic [7:0] status_i,
    output logic [7:0] rdata_o,
    output logic [7:0] control_o,
    output logic [15:0] charge_o,
    output logic [15:0] high_o,
    output logic [15:0] low_o
);
    logic [7:0] regs [REG_COUNT];
    logic [7:0] reset_val [REG_COUNT];
    assign reset_val = '{8'h00, CONTROL_RESET, CHARGE_RESET[15:8], CHARGE_RESET[7:0],
        HIGH_RESET[15:8], HIGH_RESET[7:0], LOW_RESET[15:8], LOW_RESET[7:0]};
    genvar g;
    generate
        for (g = 0; g < REG_COUNT; g++) begin : g_reg
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    regs[g] <= reset_val[g];
                end else if (wr_i && waddr_i == 4'(g) && g != 0) begin
                    regs[g] <= wdata_i;
                end
            end
        end
    endgenerate
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else if (raddr_i == REG_STATUS) begin
            rdata_o <= status_i;
        end else if (raddr_i < 4'(REG_COUNT)) begin
            rdata_o <= regs[raddr_i[2:0]];
        end else begin
            rdata_o <= 8'hFF;
        end
    end
    assign control_o = regs[1];
    assign charge_o = {regs[2], regs[3]};
    assign high_o = {regs[4], regs[5]};
    assign low_o = {regs[6], regs[7]};
endmodule // reg_bank

// File: testbench/bus_master_model.sv
`timescale 1ns/1ps
module bus_master_model (
    output logic scl_o,
    output logic sda_low_o,
    input wire logic sda_i
);
    // both lines released at idle; the clock stands still between frames
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end

    // data changes a quarter period into the low phase, sampled mid high phase
    task automatic bit_cycle(input logic low, output logic seen);
        #20 sda_low_o = low;
        #20 scl_o = 1'b1;
        #20 seen = sda_i;
        #20 scl_o = 1'b0;
    endtask

    task automatic start();
        #20 sda_low_o = 1'b0;
        #20 scl_o = 1'b1;
        #20 sda_low_o = 1'b1;
        #20 scl_o = 1'b0;
    endtask

    task automatic stop();
        #20 sda_low_o = 1'b1;
        #20 scl_o = 1'b1;
        #20 sda_low_o = 1'b0;
        #20;
    endtask

    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_cycle(!b[i], s);
        bit_cycle(1'b0, ack);
    endtask

    // lose pulls the msb low so a slave sending a one must back off
    task automatic rd_byte(input logic nak, input logic lose, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_cycle(lose && i == 7, d[i]);
        bit_cycle(!nak, s);
    endtask
endmodule // bus_master_model

// File: testbench/gauge_i2c_slave_threshold_alert_tb.sv
`timescale 1ns/1ps
module gauge_i2c_slave_threshold_alert_tb;
    import gauge_pkg::*;
    typedef struct {
        logic is_byte;
        string name;
        logic [7:0] val;
    } note_t;
    logic mclk, sys_rst, charge_up, charge_down, bad_drive;
    logic sda_o, sda_oe_n, scl_o, scl_oe_n, alert_o, alert_oe_n;
    logic m_scl, m_sda_low, scl_w, sda_w;
    logic [7:0] res_val, hm, lm, st;
    logic [6:0] a7;
    int error_cnt = 0;
    int checked = 0;
    int seed = 91;
    note_t notes[$];
    note_t cur;
    event res_ev;

    // open-drain wires with pull-ups
    assign scl_w = !(!m_scl || !scl_oe_n);
    assign sda_w = !(m_sda_low || !sda_oe_n);

    gauge_i2c_slave DUT (
        .MCLK_I(mclk), .SYS_RST_I(sys_rst), .SCL_I(scl_w), .SDA_I(sda_w),
        .CHARGE_UP_I(charge_up), .CHARGE_DOWN_I(charge_down),
        .SDA_O(sda_o), .SDA_OE_N_O(sda_oe_n), .SCL_O(scl_o), .SCL_OE_N_O(scl_oe_n),
        .ALERT_O(alert_o), .ALERT_OE_N_O(alert_oe_n));
    bus_master_model host (.scl_o(m_scl), .sda_low_o(m_sda_low), .sda_i(sda_w));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // any high drive is latched here and reported at each test end
    always @(posedge mclk) begin
        if (!sys_rst && (scl_oe_n !== 1'b1 || (sda_oe_n === 1'b0 && sda_o !== 1'b0)
            || (alert_oe_n === 1'b0 && alert_o !== 1'b0))) begin
            bad_drive <= 1'b1;
        end
    end

    task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_bit(input string n, input logic e, input logic g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %b seen %b", n, e, g);
        end
    endtask

    always @(res_ev) begin
        cur = notes.pop_front();
        if (cur.is_byte) chk_byte(cur.name, cur.val, res_val);
        else chk_bit(cur.name, cur.val[0], res_val[0]);
    end

    task automatic post(input logic [7:0] v);
        res_val = v;
        ->res_ev;
        #1;
    endtask

    task automatic send(input logic [7:0] b, input logic e);
        logic a;
        notes.push_back('{1'b0, "ack", {7'h00, e}});
        host.wr_byte(b, a);
        post({7'h00, a});
    endtask

    task automatic recv(input logic [7:0] e, input logic nak);
        logic [7:0] d;
        notes.push_back('{1'b1, "read_data", e});
        host.rd_byte(nak, 1'b0, d);
        post(d);
    endtask

    task automatic reg_write(input logic [3:0] p, input logic [7:0] q[$]);
        host.start();
        send({OWN_ADDR, 1'b0}, 1'b0);
        send({4'h0, p}, 1'b0);
        foreach (q[i]) send(q[i], 1'b0);
        host.stop();
    endtask

    task automatic reg_read(input logic [3:0] p, input logic [7:0] q[$]);
        host.start();
        send({OWN_ADDR, 1'b0}, 1'b0);
        send({4'h0, p}, 1'b0);
        host.start();
        send({OWN_ADDR, 1'b1}, 1'b0);
        foreach (q[i]) recv(q[i], i == q.size() - 1);
        host.stop();
    endtask

    task automatic ara(input logic e, input logic lose);
        logic [7:0] d;
        host.start();
        send({ALERT_RESP_ADDR, 1'b1}, e);
        if (lose) host.rd_byte(1'b1, 1'b1, d);
        else if (!e) recv({OWN_ADDR, 1'b1}, 1'b1);
        host.stop();
    endtask

    task automatic pin_check(input logic e);
        repeat (10) @(posedge mclk);
        #1;
        notes.push_back('{1'b0, "alert_pin", {7'h00, e}});
        post({7'h00, alert_oe_n});
    endtask

    task automatic pulse(input logic up);
        @(posedge mclk);
        #1 charge_up = up;
        charge_down = !up;
        @(posedge mclk);
        #1 charge_up = 1'b0;
        charge_down = 1'b0;
    endtask

    task automatic test_end(input string n);
        notes.push_back('{1'b0, "high_drive", 8'h00});
        post({7'h00, bad_drive});
        $display("test %s done, mismatches so far %0d", n, error_cnt);
    endtask

    task automatic complete_run();
        $display("compares %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        #300000;
        error_cnt++;
        $display("mismatch watchdog expected done seen hang");
        complete_run();
    end

    initial begin
        sys_rst = 1'b1;
        charge_up = 1'b0;
        charge_down = 1'b0;
        bad_drive = 1'b0;
        repeat (4) @(posedge mclk);
        #1 sys_rst = 1'b0;
        repeat (8) @(posedge mclk);
        reg_read(REG_STATUS, '{STATUS_FIXED, CONTROL_RESET, CHARGE_RESET[15:8],
            CHARGE_RESET[7:0], HIGH_RESET[15:8], HIGH_RESET[7:0], LOW_RESET[15:8],
            LOW_RESET[7:0], 8'hFF});
        pin_check(1'b1);
        test_end("reset_values");
        repeat (4) begin
            a7 = 7'($random(seed));
            if (a7 == OWN_ADDR || a7 == ALERT_RESP_ADDR) a7 = 7'h7F;
            host.start();
            send({a7, 1'b0}, 1'b1);
            host.stop();
        end
        ara(1'b1, 1'b0);
        test_end("refusals");
        // byte values chosen so no partial charge write crosses a threshold
        hm = 8'h80 + 8'($random(seed) & 32'h3F);
        lm = 8'h10 + 8'($random(seed) & 32'h3F);
        reg_write(REG_HIGH_MSB, '{hm, 8'h80, lm, 8'h80});
        reg_read(REG_HIGH_MSB, '{hm, 8'h80, lm, 8'h80});
        test_end("thresholds");
        reg_write(REG_CHARGE_LSB, '{8'h80});
        reg_write(REG_CHARGE_MSB, '{hm});
        reg_read(REG_STATUS, '{STATUS_FIXED});
        pin_check(1'b1);
        st = STATUS_FIXED | (8'h01 << FLAG_HIGH);
        reg_write(REG_CHARGE_LSB, '{8'h81});
        reg_read(REG_STATUS, '{st});
        pin_check(1'b0);
        // pin field cleared: alert pending but line released and no alert response
        reg_write(REG_CONTROL, '{CONTROL_RESET & ~(8'h03 << PIN_MODE_LSB)});
        pin_check(1'b1);
        ara(1'b1, 1'b0);
        reg_write(REG_CONTROL, '{CONTROL_RESET});
        pin_check(1'b0);
        test_end("high_crossing");
        ara(1'b0, 1'b0);
        pin_check(1'b1);
        ara(1'b1, 1'b0);
        test_end("alert_response");
        reg_write(REG_CHARGE_LSB, '{8'h80});
        reg_write(REG_CHARGE_MSB, '{lm});
        reg_read(REG_STATUS, '{st});
        reg_write(REG_CHARGE_LSB, '{8'h7F});
        st = st | (8'h01 << FLAG_LOW);
        reg_read(REG_STATUS, '{st});
        ara(1'b0, 1'b1);
        pin_check(1'b0);
        ara(1'b0, 1'b0);
        pin_check(1'b1);
        test_end("low_crossing");
        pulse(1'b0);
        st = st | (8'h01 << FLAG_OVERFLOW);
        reg_read(REG_STATUS, '{st});
        pin_check(1'b0);
        ara(1'b0, 1'b0);
        pulse(1'b1);
        pin_check(1'b1);
        test_end("overflow");
        complete_run();
    end
endmodule // gauge_i2c_slave_threshold_alert_tb
